//--- hdl/mmdia_pkg.sv
// Constants, field layouts and types for the indirect extended register access block
package mmdia_pkg;

  // ==========================================================================
  // Register map
  localparam logic [4:0] REG_ACCESS_CTRL = 5'h0D;
  localparam logic [4:0] REG_ADDR_DATA = 5'h0E;
  localparam logic [4:0] DEV_ADDR_VENDOR = 5'h1F;

  // ==========================================================================
  // Function codes
  localparam logic [1:0] FN_ADDRESS = 2'h0;
  localparam logic [1:0] FN_DATA = 2'h1;
  localparam logic [1:0] FN_DATA_INC_RW = 2'h2;
  localparam logic [1:0] FN_DATA_INC_WR = 2'h3;

  // ==========================================================================
  // Management frame op codes and lengths
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [3:0] HDR_LAST = 4'hB;
  localparam logic [3:0] TA_LAST = 4'h1;
  localparam logic [3:0] DATA_LAST = 4'hF;
  localparam int STD_REG_COUNT = 32;
  localparam int EXT_DEPTH_DEF = 64;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] ACCESS_CTRL_RST = 16'h0000;
  localparam logic [15:0] EXT_ADDR_RST = 16'h0000;
  localparam logic [15:0] REG_RST = 16'h0000;
  localparam logic [4:0] PHY_ADDR_RST = 5'h00;

  // ==========================================================================
  // Types
  typedef struct packed {
    logic [1:0] func;
    logic [8:0] rsvd;
    logic [4:0] dev_addr;
  } mmdia_ctrl_t;

  typedef struct packed {
    logic [1:0] op;
    logic [4:0] phy;
    logic [4:0] reg_addr;
  } mmdia_hdr_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_HDR,
    ST_TA,
    ST_DATA
  } mmdia_state_t;

endpackage

//--- hdl/mmdia_top.sv
// Management frame slave with indirect extended register access
`timescale 1ns/1ns
module mmdia_top
#(
  parameter int EXT_DEPTH = mmdia_pkg::EXT_DEPTH_DEF
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Management pins
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe_o,
  // Address strap
  input wire logic [4:0] phy_addr_i
);

  localparam int IW = $clog2(EXT_DEPTH);
  localparam logic [15:0] DEPTH_W = 16'(EXT_DEPTH);

  // ==========================================================================
  // Synchronisers
  logic mdc_s1_ff;
  logic mdc_s2_ff;
  logic mdc_s3_ff;
  logic mdio_s1_ff;
  logic mdio_s2_ff;
  logic [4:0] phy_s1_ff;
  logic [4:0] phy_s2_ff;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mdc_s1_ff <= 1'b0;
      mdc_s2_ff <= 1'b0;
      mdc_s3_ff <= 1'b0;
      mdio_s1_ff <= 1'b1;
      mdio_s2_ff <= 1'b1;
      phy_s1_ff <= mmdia_pkg::PHY_ADDR_RST;
      phy_s2_ff <= mmdia_pkg::PHY_ADDR_RST;
    end
    else
    begin
      mdc_s1_ff <= mdc_i;
      mdc_s2_ff <= mdc_s1_ff;
      mdc_s3_ff <= mdc_s2_ff;
      mdio_s1_ff <= mdio_i;
      mdio_s2_ff <= mdio_s1_ff;
      phy_s1_ff <= phy_addr_i;
      phy_s2_ff <= phy_s1_ff;
    end
  end

  logic rise;
  logic bit_in;
  assign rise = mdc_s2_ff & ~mdc_s3_ff;
  assign bit_in = mdio_s2_ff;

  // ==========================================================================
  // Strap capture once after reset release
  logic [4:0] phyad_ff;
  logic [1:0] strap_cnt_ff;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      phyad_ff <= mmdia_pkg::PHY_ADDR_RST;
      strap_cnt_ff <= 2'h0;
    end
    else if (strap_cnt_ff != 2'h3)
    begin
      strap_cnt_ff <= strap_cnt_ff + 2'h1;
      if (strap_cnt_ff == 2'h2)
      begin
        phyad_ff <= phy_s2_ff;
      end
    end
  end

  // ==========================================================================
  // Register storage
  mmdia_pkg::mmdia_ctrl_t ctrl_ff;
  logic [15:0] ext_addr_ff;
  logic [15:0] mem_ff [EXT_DEPTH];

  logic dev_ok;
  logic ind_ok;
  assign dev_ok = (ctrl_ff.dev_addr == mmdia_pkg::DEV_ADDR_VENDOR);
  // Indirect target must exist and must not be one of the two access registers
  assign ind_ok = (ext_addr_ff < DEPTH_W)
                  && (ext_addr_ff != {11'h000, mmdia_pkg::REG_ACCESS_CTRL})
                  && (ext_addr_ff != {11'h000, mmdia_pkg::REG_ADDR_DATA});

  // Read value for a direct register address
  function automatic logic [15:0] rd_value(input logic [4:0] ra);
    logic [15:0] v;
    v = mmdia_pkg::REG_RST;
    if (ra == mmdia_pkg::REG_ACCESS_CTRL)
    begin
      v = ctrl_ff;
    end
    else if (ra == mmdia_pkg::REG_ADDR_DATA)
    begin
      if (!dev_ok)
      begin
        v = mmdia_pkg::REG_RST;
      end
      else if (ctrl_ff.func == mmdia_pkg::FN_ADDRESS)
      begin
        v = ext_addr_ff;
      end
      else if (ind_ok)
      begin
        v = mem_ff[ext_addr_ff[IW-1:0]];
      end
    end
    else
    begin
      v = mem_ff[IW'(ra)];
    end
    return v;
  endfunction

  // ==========================================================================
  // Frame sequencer
  mmdia_pkg::mmdia_state_t st_ff;
  logic [3:0] cnt_ff;
  mmdia_pkg::mmdia_hdr_t hdr_ff;
  mmdia_pkg::mmdia_hdr_t hdr_next;
  logic [15:0] sh_ff;
  logic act_ff;
  logic rd_ff;

  assign hdr_next = mmdia_pkg::mmdia_hdr_t'({hdr_ff[10:0], bit_in});

  logic hdr_done;
  logic data_done;
  logic wr_done;
  logic rd_done;
  logic [15:0] wdata;
  assign hdr_done = rise && (st_ff == mmdia_pkg::ST_HDR) && (cnt_ff == mmdia_pkg::HDR_LAST);
  assign data_done = rise && (st_ff == mmdia_pkg::ST_DATA) && (cnt_ff == mmdia_pkg::DATA_LAST);
  assign wr_done = data_done && act_ff && !rd_ff;
  assign rd_done = data_done && act_ff && rd_ff;
  assign wdata = {sh_ff[14:0], bit_in};

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      st_ff <= mmdia_pkg::ST_IDLE;
      cnt_ff <= 4'h0;
      hdr_ff <= '0;
      sh_ff <= 16'h0000;
      act_ff <= 1'b0;
      rd_ff <= 1'b0;
      mdio_o <= 1'b1;
      mdio_oe_o <= 1'b0;
    end
    else if (rise)
    begin
      case (st_ff)
        mmdia_pkg::ST_IDLE:
        begin
          mdio_oe_o <= 1'b0;
          if (!bit_in)
          begin
            st_ff <= mmdia_pkg::ST_START;
          end
        end
        mmdia_pkg::ST_START:
        begin
          st_ff <= bit_in ? mmdia_pkg::ST_HDR : mmdia_pkg::ST_IDLE;
          cnt_ff <= 4'h0;
        end
        mmdia_pkg::ST_HDR:
        begin
          hdr_ff <= hdr_next;
          cnt_ff <= cnt_ff + 4'h1;
          if (hdr_done)
          begin
            st_ff <= mmdia_pkg::ST_TA;
            cnt_ff <= 4'h0;
            act_ff <= (hdr_next.phy == phyad_ff)
                      && ((hdr_next.op == mmdia_pkg::OP_READ)
                          || (hdr_next.op == mmdia_pkg::OP_WRITE));
            rd_ff <= (hdr_next.op == mmdia_pkg::OP_READ);
            sh_ff <= rd_value(hdr_next.reg_addr);
          end
        end
        mmdia_pkg::ST_TA:
        begin
          cnt_ff <= cnt_ff + 4'h1;
          if (cnt_ff == 4'h0)
          begin
            // Second turnaround bit is driven low on a matched read
            mdio_oe_o <= act_ff && rd_ff;
            mdio_o <= 1'b0;
          end
          else if (cnt_ff == mmdia_pkg::TA_LAST)
          begin
            st_ff <= mmdia_pkg::ST_DATA;
            cnt_ff <= 4'h0;
            mdio_o <= sh_ff[15];
            if (act_ff && rd_ff)
            begin
              sh_ff <= {sh_ff[14:0], 1'b0};
            end
          end
        end
        mmdia_pkg::ST_DATA:
        begin
          cnt_ff <= cnt_ff + 4'h1;
          if (act_ff && rd_ff)
          begin
            mdio_o <= sh_ff[15];
            sh_ff <= {sh_ff[14:0], 1'b0};
          end
          else
          begin
            sh_ff <= wdata;
          end
          if (cnt_ff == mmdia_pkg::DATA_LAST)
          begin
            st_ff <= mmdia_pkg::ST_IDLE;
            mdio_oe_o <= 1'b0;
            mdio_o <= 1'b1;
          end
        end
        default:
        begin
          st_ff <= mmdia_pkg::ST_IDLE;
          mdio_oe_o <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Access control register, direct access only
  logic wr_ctrl;
  logic wr_ad;
  logic rd_ad;
  assign wr_ctrl = wr_done && (hdr_ff.reg_addr == mmdia_pkg::REG_ACCESS_CTRL);
  assign wr_ad = wr_done && (hdr_ff.reg_addr == mmdia_pkg::REG_ADDR_DATA) && dev_ok;
  assign rd_ad = rd_done && (hdr_ff.reg_addr == mmdia_pkg::REG_ADDR_DATA) && dev_ok;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ctrl_ff <= mmdia_pkg::ACCESS_CTRL_RST;
    end
    else if (wr_ctrl)
    begin
      ctrl_ff <= wdata;
    end
  end

  // ==========================================================================
  // Extended address register with post increment
  logic inc_addr;
  assign inc_addr = (wr_ad && ((ctrl_ff.func == mmdia_pkg::FN_DATA_INC_RW)
                               || (ctrl_ff.func == mmdia_pkg::FN_DATA_INC_WR)))
                    || (rd_ad && (ctrl_ff.func == mmdia_pkg::FN_DATA_INC_RW));

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ext_addr_ff <= mmdia_pkg::EXT_ADDR_RST;
    end
    else if (wr_ad && (ctrl_ff.func == mmdia_pkg::FN_ADDRESS))
    begin
      ext_addr_ff <= wdata;
    end
    else if (inc_addr)
    begin
      ext_addr_ff <= ext_addr_ff + 16'h0001;
    end
  end

  // ==========================================================================
  // Register array: entries below 32 are the standard set, the rest extended
  logic wr_std;
  logic wr_ext;
  assign wr_std = wr_done && (hdr_ff.reg_addr != mmdia_pkg::REG_ACCESS_CTRL)
                  && (hdr_ff.reg_addr != mmdia_pkg::REG_ADDR_DATA);
  assign wr_ext = wr_ad && (ctrl_ff.func != mmdia_pkg::FN_ADDRESS) && ind_ok;

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      for (int i = 0; i < EXT_DEPTH; i++)
      begin
        mem_ff[i] <= mmdia_pkg::REG_RST;
      end
    end
    else if (wr_std)
    begin
      mem_ff[IW'(hdr_ff.reg_addr)] <= wdata;
    end
    else if (wr_ext)
    begin
      mem_ff[ext_addr_ff[IW-1:0]] <= wdata;
    end
  end

endmodule

//--- verif/mmdia_chk_sva.sv
// Pin-level checker for the management data pin
`timescale 1ns/1ns
module mmdia_chk
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // Management pins
  input wire logic mdc_i,
  input wire logic mdio_o,
  input wire logic mdio_oe_o
);
  logic mdc_q_ff;
  logic [3:0] idle_ff;
  logic [4:0] rise_ff;
  logic rise;

  assign rise = mdc_i & ~mdc_q_ff;

  // ==========================================================================
  // Cycles since the last pin rise, and rises seen while driving
  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
    begin
      mdc_q_ff <= 1'b0;
      idle_ff <= 4'hF;
    end
    else
    begin
      mdc_q_ff <= mdc_i;
      idle_ff <= rise ? 4'h0 : (idle_ff == 4'hF ? idle_ff : idle_ff + 4'h1);
    end

  always_ff @(posedge clk_i or negedge nrst_i)
    if (!nrst_i)
      rise_ff <= 5'h00;
    else if (!mdio_oe_o)
      rise_ff <= 5'h00;
    else if (rise)
      rise_ff <= rise_ff + 5'h01;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  a_release_quiet: assert property (!$past(nrst_i) |-> !mdio_oe_o && mdio_o)
    else $error("pin driven right after reset");
  a_ta_low: assert property ($rose(mdio_oe_o) |-> !mdio_o)
    else $error("turnaround bit not zero");
  a_release_high: assert property ($fell(mdio_oe_o) |-> mdio_o)
    else $error("data left low at release");
  a_bit_stands: assert property (rise && mdio_oe_o |=> ($stable(mdio_o) && mdio_oe_o)[*2])
    else $error("read bit moved at sampling");
  a_change_near: assert property ($changed(mdio_oe_o) || (mdio_oe_o && $changed(mdio_o))
    |-> idle_ff <= 4'hA)
    else $error("pin changed away from a clock rise");
  a_quiet_idle: assert property (idle_ff == 4'hF |-> !mdio_oe_o)
    else $error("pin driven with clock stopped");
  a_read_len: assert property ($fell(mdio_oe_o) |-> rise_ff inside {5'h11, 5'h12})
    else $error("read drive length wrong");
  a_read_min: assert property ($rose(mdio_oe_o) |=> mdio_oe_o[*8])
    else $error("read drive too short");
endmodule

bind mmdia_top mmdia_chk mmdia_chk_inst (.clk_i(clk_i), .nrst_i(nrst_i), .mdc_i(mdc_i),
  .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o));

//--- verif/mmdia_sta_model.sv
// Station management model that clocks frames onto the management pins
`timescale 1ns/1ns
module mmdia_sta_model
(
  // Clock
  input wire logic clk_i,
  // Management pins
  input wire logic mdio_i,
  output logic mdc_o,
  output logic mdio_o,
  output logic mdio_oe_o
);
  initial
  begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    mdio_oe_o = 1'b0;
  end

  // ==========================================================================
  // One bit: 4 clk low, 4 clk high, read half a clk after the rise
  task automatic put_bit(input logic drv, input logic val, output logic smp);
    @(posedge clk_i);
    mdc_o <= 1'b0;
    mdio_oe_o <= drv;
    mdio_o <= val;
    repeat (4) @(posedge clk_i);
    mdc_o <= 1'b1;
    @(negedge clk_i);
    smp = mdio_i;
    repeat (3) @(posedge clk_i);
  endtask

  // Line released from the first turnaround bit on for reads; clock parked low after
  task automatic frame(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
    input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] bits;
    logic smp;
    bits = {2'b01, op, phy, ra, 2'b10, wd};
    rd = 16'h0000;
    for (int i = 31; i >= 0; i--)
    begin
      put_bit(op != mmdia_pkg::OP_READ || i > 17, bits[i], smp);
      if (i < 16)
        rd[i] = smp;
    end
    @(posedge clk_i);
    mdc_o <= 1'b0;
    mdio_oe_o <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask
endmodule

//--- verif/tb_mmdia_top.sv
// Self-checking bench for the indirect extended register access block
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module tb_mmdia_top;
  localparam logic [4:0] PHY = 5'h05;
  localparam logic [4:0] CR = mmdia_pkg::REG_ACCESS_CTRL;
  localparam logic [4:0] AD = mmdia_pkg::REG_ADDR_DATA;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic mdc, sta_o, sta_oe, dut_o, dut_oe;
  wire logic mdio;
  int n_mismatch = 0;
  int cmp_count = 0;

  always #5 clk_i = ~clk_i;
  assign mdio = dut_oe ? dut_o : (sta_oe ? sta_o : 1'b1);

  mmdia_top mmdia_top_inst (.clk_i(clk_i), .nrst_i(nrst_i), .mdc_i(mdc), .mdio_i(mdio),
    .mdio_o(dut_o), .mdio_oe_o(dut_oe), .phy_addr_i(PHY));
  mmdia_sta_model mmdia_sta_model_inst (.clk_i(clk_i), .mdio_i(mdio), .mdc_o(mdc),
    .mdio_o(sta_o), .mdio_oe_o(sta_oe));

  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================================
  // Frame helpers
  task automatic wr(input logic [4:0] ra, input logic [15:0] d);
    logic [15:0] x;
    mmdia_sta_model_inst.frame(mmdia_pkg::OP_WRITE, PHY, ra, d, x);
  endtask
  task automatic rdc(input logic [4:0] ra, input logic [15:0] e);
    logic [15:0] x;
    mmdia_sta_model_inst.frame(mmdia_pkg::OP_READ, PHY, ra, 16'h0000, x);
    `CHK(x, e)
  endtask
  task automatic ld(input logic [15:0] a);
    wr(CR, 16'h001F);
    wr(AD, a);
  endtask
  task automatic addr_is(input logic [15:0] e);
    wr(CR, 16'h001F);
    rdc(AD, e);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_direct();
    logic [15:0] x;
    rdc(CR, 16'h0000);
    wr(5'h03, 16'hA5C3);
    mmdia_sta_model_inst.frame(mmdia_pkg::OP_WRITE, PHY ^ 5'h01, 5'h03, 16'h1111, x);
    mmdia_sta_model_inst.frame(mmdia_pkg::OP_READ, PHY ^ 5'h01, 5'h03, 16'h0000, x);
    `CHK(x, 16'hFFFF)
    // Unknown op code: frame must be walked with no effect on storage
    mmdia_sta_model_inst.frame(2'h3, PHY, 5'h03, 16'h2222, x);
    rdc(5'h03, 16'hA5C3);
  endtask
  task automatic t_addr_mode();
    ld(16'h0040);
    wr(AD, 16'h0023);
    rdc(AD, 16'h0023);
    rdc(AD, 16'h0023);
    rdc(CR, 16'h001F);
  endtask
  task automatic t_no_inc();
    wr(CR, 16'h401F);
    wr(AD, 16'h1234);
    wr(AD, 16'h5678);
    rdc(AD, 16'h5678);
    rdc(AD, 16'h5678);
    addr_is(16'h0023);
    ld(16'h0003);
    wr(CR, 16'h401F);
    rdc(AD, 16'hA5C3);
    wr(AD, 16'h3C3C);
    rdc(5'h03, 16'h3C3C);
  endtask
  task automatic t_inc_rw();
    ld(16'h0030);
    wr(CR, 16'h801F);
    wr(AD, 16'h0A0A);
    wr(AD, 16'h0B0B);
    addr_is(16'h0032);
    ld(16'h0030);
    wr(CR, 16'h801F);
    rdc(AD, 16'h0A0A);
    rdc(AD, 16'h0B0B);
    addr_is(16'h0032);
  endtask
  task automatic t_inc_wr();
    ld(16'h0034);
    wr(CR, 16'hC01F);
    wr(AD, 16'h0C0C);
    rdc(AD, 16'h0000);
    rdc(AD, 16'h0000);
    addr_is(16'h0035);
    ld(16'h0034);
    wr(CR, 16'h401F);
    rdc(AD, 16'h0C0C);
  endtask
  task automatic t_target_device_address();
    ld(16'h0031);
    wr(CR, 16'h801E);
    wr(AD, 16'hDEAD);
    rdc(AD, 16'h0000);
    addr_is(16'h0031);
    wr(CR, 16'h401F);
    rdc(AD, 16'h0B0B);
  endtask
  task automatic t_protect();
    ld(16'h000D);
    wr(CR, 16'h801F);
    wr(AD, 16'h9999);
    rdc(CR, 16'h801F);
    wr(AD, 16'h7777);
    rdc(AD, 16'h0000);
    addr_is(16'h0010);
  endtask
  task automatic t_wrap();
    ld(16'hFFFF);
    wr(CR, 16'h801F);
    rdc(AD, 16'h0000);
    addr_is(16'h0000);
  endtask

  initial
  begin
    repeat (100000) @(posedge clk_i);
    n_mismatch++;
    give_verdict();
  end

  initial
  begin
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    t_direct();
    t_addr_mode();
    t_no_inc();
    t_inc_rw();
    t_inc_wr();
    t_target_device_address();
    t_protect();
    t_wrap();
    give_verdict();
  end
endmodule
